// [fpt_table.sv]
`timescale 1ns/100ps
module fpt_table
  import fpt_pkg::*;
(
  // Clock and reset
  input  wire logic          CLK,
  input  wire logic          SRST,
  // Read control
  input  wire logic          START,
  input  wire logic [4:0]    START_ADDR,
  input  wire logic          NEXT,
  // Read data
  output logic      [7:0]    DATA,
  output logic               VALID,
  output logic [4:0]         ADDR,
  // Fixed capability flags
  output logic               QCM_SUPPORTED,
  output logic               QCM_OPCODE_OK
);
  logic [4:0] addr_r;
  logic [4:0] addr_nxt;
  logic       valid_r;
  logic [7:0] rom_data;

  // Address walker
  always_comb begin
    addr_nxt = addr_r;
    if (SRST) begin
      addr_nxt = FPT_FIRST;
    end else if (START) begin
      addr_nxt = START_ADDR;
    end else if (valid_r && NEXT) begin
      addr_nxt = (addr_r == FPT_LAST) ? FPT_FIRST
                                      : addr_r + FPT_ONE;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      addr_r <= FPT_FIRST;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  // Data ready one cycle after address is set
  always_ff @(posedge CLK) begin
    if (SRST) begin
      valid_r <= 1'b0;
    end else if (START) begin
      valid_r <= 1'b0;
    end else if (NEXT && valid_r) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= 1'b1;
    end
  end

  fpt_rom u_rom (
    .clk    (CLK),
    .addr   (addr_nxt),
    .data_r (rom_data)
  );

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ADDR <= FPT_FIRST;
    end else begin
      ADDR <= addr_nxt;
    end
  end

  assign DATA          = rom_data;
  assign VALID         = valid_r;
  assign QCM_SUPPORTED = FPT_QCM_FLAGS[FPT_QCM_BIT];
  assign QCM_OPCODE_OK = (FPT_QCM_OP == FPT_QIO_OP);

  // Table bytes
  rom_dual_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h0C)
    |-> (DATA == 8'h08))
    else $error("dual out byte wrong");

  dual_field_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h0C)
    |-> (DATA[7:5] == 3'h0 && DATA[4:0] == 5'h08))
    else $error("dual out fields wrong");

  rom_do_op_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h0D)
    |-> (DATA == 8'h3B))
    else $error("dual out opcode wrong");

  rom_dio_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h0E)
    |-> (DATA == 8'h88))
    else $error("dual io byte wrong");

  dio_field_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h0E)
    |-> (DATA[7:5] == 3'h4 && DATA[4:0] == 5'h08))
    else $error("dual io fields wrong");

  rom_dio_op_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h0F)
    |-> (DATA == 8'hBB))
    else $error("dual io opcode wrong");

  rom_flag_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h10)
    |-> (DATA == 8'hFE))
    else $error("flag byte wrong");

  flag_bits_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h10)
    |-> (DATA[4] == 1'b1 && DATA[0] == 1'b0))
    else $error("flag bits wrong");

  rom_rsvd_a: assert property (@(posedge CLK) disable iff (SRST)
    ((ADDR >= 5'h11 && ADDR <= 5'h17) || ADDR == 5'h18 || ADDR == 5'h19)
    |-> (DATA == 8'hFF))
    else $error("reserved byte wrong");

  low_rsvd_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR < 5'h0C)
    |-> (DATA == 8'hFF))
    else $error("uncovered byte wrong");

  dual_wire_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h16)
    |-> (DATA[7:5] == 3'h7 && DATA[4:0] == 5'h1F))
    else $error("dual all byte wrong");

  da_op_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h17)
    |-> (DATA == 8'hFF))
    else $error("dual all opcode wrong");

  rom_qcm_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h1A)
    |-> (DATA == 8'h48))
    else $error("quad mode byte wrong");

  qcm_field_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h1A)
    |-> (DATA[7:5] == 3'h2 && DATA[4:0] == 5'h08))
    else $error("quad mode fields wrong");

  rom_qop_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h1B)
    |-> (DATA == 8'hEB))
    else $error("quad opcode wrong");

  rom_er1_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h1C)
    |-> (DATA == 8'h0C))
    else $error("erase1 size wrong");

  er1_op_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h1D)
    |-> (DATA == 8'h20))
    else $error("erase1 opcode wrong");

  er2_size_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h1E)
    |-> (DATA == 8'h0F))
    else $error("erase2 size wrong");

  rom_er2_a: assert property (@(posedge CLK) disable iff (SRST)
    (ADDR == 5'h1F)
    |-> (DATA == 8'h52))
    else $error("erase2 opcode wrong");

  // Read sequencing
  reset_state_a: assert property (@(posedge CLK)
    SRST
    |=> (ADDR == 5'h0C && !VALID && DATA == 8'h08))
    else $error("reset state wrong");

  start_load_a: assert property (@(posedge CLK) disable iff (SRST)
    START
    |=> (ADDR == $past(START_ADDR) && !VALID))
    else $error("start not loaded");

  addr_step_a: assert property (@(posedge CLK) disable iff (SRST)
    (valid_r && NEXT && !START && addr_r != FPT_LAST)
    |=> (addr_r == $past(addr_r) + 5'h01))
    else $error("address did not advance");

  addr_wrap_a: assert property (@(posedge CLK) disable iff (SRST)
    (valid_r && NEXT && !START && addr_r == FPT_LAST)
    |=> (addr_r == FPT_FIRST))
    else $error("address did not wrap");

  next_drop_a: assert property (@(posedge CLK) disable iff (SRST)
    (valid_r && NEXT && !START)
    |=> !VALID)
    else $error("valid held after step");

  next_refuse_a: assert property (@(posedge CLK) disable iff (SRST)
    (!valid_r && NEXT && !START)
    |=> (addr_r == $past(addr_r)))
    else $error("early step not refused");

  valid_rise_a: assert property (@(posedge CLK) disable iff (SRST)
    (!valid_r && !START)
    |=> valid_r)
    else $error("valid did not rise");

  valid_hold_a: assert property (@(posedge CLK) disable iff (SRST)
    (VALID && !START && !NEXT)
    |=> VALID)
    else $error("valid dropped");

  data_hold_a: assert property (@(posedge CLK) disable iff (SRST)
    (!START && !(NEXT && valid_r))
    |=> ($stable(DATA) && $stable(ADDR)))
    else $error("data not held");
endmodule

// [fpt_pkg.sv]
// What this block does
// - Byte 0Ch 08h, 0Dh dual-output opcode
// - Byte 0Eh 88h, 0Fh dual I/O BBh
// - Byte 10h FEh, quad-command mode supported
// - Reserved bytes 11h-15h, 18h-19h read FFh
// - Bytes 16h, 17h all-dual-wire unsupported, FFh
// - Byte 1Ah 48h, two mode, eight dummy
// - Byte 1Bh EBh quad-command-mode read opcode
// - Bytes 1Ch 0Ch, 1Dh 20h: 4 KB erase
// - Bytes 1Eh 0Fh, 1Fh 52h: 32 KB erase
package fpt_pkg;
  localparam int          FPT_AW        = 5;
  localparam logic [4:0]  FPT_FIRST     = 5'h0C;
  localparam logic [4:0]  FPT_LAST      = 5'h1F;
  localparam logic [4:0]  FPT_ONE       = 5'h01;
  localparam logic [2:0]  FPT_DO_MODE   = 3'h0;
  localparam logic [4:0]  FPT_DO_DUMMY  = 5'h08;
  localparam logic [7:0]  FPT_DO_OP     = 8'h3B;
  localparam logic [2:0]  FPT_DIO_MODE  = 3'h4;
  localparam logic [4:0]  FPT_DIO_DUMMY = 5'h08;
  localparam logic [7:0]  FPT_DIO_OP    = 8'hBB;
  localparam logic [7:0]  FPT_QCM_FLAGS = 8'hFE;
  localparam logic [7:0]  FPT_RSVD      = 8'hFF;
  localparam logic [2:0]  FPT_DA_MODE   = 3'h7;
  localparam logic [4:0]  FPT_DA_DUMMY  = 5'h1F;
  localparam logic [7:0]  FPT_DA_OP     = 8'hFF;
  localparam logic [2:0]  FPT_QCM_MODE  = 3'h2;
  localparam logic [4:0]  FPT_QCM_DUMMY = 5'h08;
  localparam logic [7:0]  FPT_QCM_OP    = 8'hEB;
  localparam logic [7:0]  FPT_ER1_SIZE  = 8'h0C;
  localparam logic [7:0]  FPT_ER1_OP    = 8'h20;
  localparam logic [7:0]  FPT_ER2_SIZE  = 8'h0F;
  localparam logic [7:0]  FPT_ER2_OP    = 8'h52;
  localparam int          FPT_QCM_BIT   = 4;
  localparam int          FPT_DA_BIT    = 0;
  localparam logic [7:0]  FPT_QIO_OP    = 8'hEB;
  localparam logic [4:0]  FPT_A_DO_CFG  = 5'h0C;
  localparam logic [4:0]  FPT_A_DO_OP   = 5'h0D;
  localparam logic [4:0]  FPT_A_DIO_CFG = 5'h0E;
  localparam logic [4:0]  FPT_A_DIO_OP  = 5'h0F;
  localparam logic [4:0]  FPT_A_FLAGS   = 5'h10;
  localparam logic [4:0]  FPT_A_DA_CFG  = 5'h16;
  localparam logic [4:0]  FPT_A_DA_OP   = 5'h17;
  localparam logic [4:0]  FPT_A_QCM_CFG = 5'h1A;
  localparam logic [4:0]  FPT_A_QCM_OP  = 5'h1B;
  localparam logic [4:0]  FPT_A_ER1_SZ  = 5'h1C;
  localparam logic [4:0]  FPT_A_ER1_OP  = 5'h1D;
  localparam logic [4:0]  FPT_A_ER2_SZ  = 5'h1E;
  localparam logic [4:0]  FPT_A_ER2_OP  = 5'h1F;
endpackage

// [fpt_rom.sv]
`timescale 1ns/100ps
module fpt_rom
  import fpt_pkg::*;
(
  // Clock
  input  wire logic          clk,
  // Read port
  input  wire logic [4:0]    addr,
  output logic      [7:0]    data_r
);
  logic [7:0] rom_v;

  always_comb begin
    rom_v = FPT_RSVD;
    case (addr)
      FPT_A_DO_CFG:  rom_v = {FPT_DO_MODE, FPT_DO_DUMMY};
      FPT_A_DO_OP:   rom_v = FPT_DO_OP;
      FPT_A_DIO_CFG: rom_v = {FPT_DIO_MODE, FPT_DIO_DUMMY};
      FPT_A_DIO_OP:  rom_v = FPT_DIO_OP;
      FPT_A_FLAGS:   rom_v = FPT_QCM_FLAGS;
      FPT_A_DA_CFG:  rom_v = {FPT_DA_MODE, FPT_DA_DUMMY};
      FPT_A_DA_OP:   rom_v = FPT_DA_OP;
      FPT_A_QCM_CFG: rom_v = {FPT_QCM_MODE, FPT_QCM_DUMMY};
      FPT_A_QCM_OP:  rom_v = FPT_QCM_OP;
      FPT_A_ER1_SZ:  rom_v = FPT_ER1_SIZE;
      FPT_A_ER1_OP:  rom_v = FPT_ER1_OP;
      FPT_A_ER2_SZ:  rom_v = FPT_ER2_SIZE;
      FPT_A_ER2_OP:  rom_v = FPT_ER2_OP;
      default: rom_v = FPT_RSVD;
    endcase
  end

  always_ff @(posedge clk) begin
    data_r <= rom_v;
  end
endmodule

// [fpt_host.sv]
`timescale 1ns/100ps
module fpt_host (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req,
  input  wire logic [4:0] req_addr,
  input  wire logic       step,
  input  wire logic       kick,
  input  wire logic       valid,
  output logic            start,
  output logic [4:0]      start_addr,
  output logic            next
);
  // start is req one cycle late; step gives one next per valid byte, kick forces next
  always_ff @(posedge clk) begin
    start      <= req;
    start_addr <= req_addr;
    next       <= ~rst & ((step & valid & ~next & ~req) | kick);
  end
endmodule

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import fpt_pkg::*;
  logic        CLK, SRST, req, step, kick, START, NEXT, VALID, QS, QO;
  logic [4:0]  req_addr, START_ADDR, ADDR;
  logic [7:0]  DATA;
  logic [31:0] rs = 32'h066611A7;
  int          miscompares, n_tests;
  fpt_host i_fpt_host (.clk(CLK), .rst(SRST), .req(req),
    .req_addr(req_addr), .step(step), .kick(kick), .valid(VALID),
    .start(START),
    .start_addr(START_ADDR), .next(NEXT));
  fpt_table i_fpt_table (.CLK(CLK), .SRST(SRST), .START(START),
    .START_ADDR(START_ADDR), .NEXT(NEXT), .DATA(DATA), .VALID(VALID),
    .ADDR(ADDR), .QCM_SUPPORTED(QS), .QCM_OPCODE_OK(QO));
  function automatic logic [7:0] tbl(input logic [4:0] a);
    case (a)
      5'h0C: return 8'h08;
      5'h0D: return 8'h3B;
      5'h0E: return 8'h88;
      5'h0F: return 8'hBB;
      5'h10: return 8'hFE;
      5'h1A: return 8'h48;
      5'h1B: return 8'hEB;
      5'h1C: return 8'h0C;
      5'h1D: return 8'h20;
      5'h1E: return 8'h0F;
      5'h1F: return 8'h52;
      default: return 8'hFF;
    endcase
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic close_out();
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic rd(input logic [4:0] a);
    int k;
    @(posedge CLK);
    req      <= 1'b1;
    req_addr <= a;
    @(posedge CLK);
    req <= 1'b0;
    repeat (2) @(posedge CLK);
    k = 0;
    do @(negedge CLK); while (VALID !== 1'b1 && ++k < 9);
    chk({3'h0, ADDR}, {3'h0, a});
    chk(DATA, tbl(a));
  endtask
  task automatic walk(input int n);
    logic [4:0] p;
    int k;
    p = ADDR;
    repeat (n) begin
      p = (p == 5'h1F) ? 5'h0C : p + 5'h01;
      k = 0;
      do begin
        @(posedge CLK);
        rs = xs(rs);
        step <= rs[0];
        @(negedge CLK);
        k++;
      end while (!(VALID === 1'b1 && ADDR === p) && k < 50);
      chk({3'h0, ADDR}, {3'h0, p});
      chk(DATA, tbl(p));
    end
    @(posedge CLK);
    step <= 1'b0;
  endtask
  task automatic refuse(input logic [4:0] a);
    logic [4:0] e;
    rd(a);
    e = (a == FPT_LAST) ? FPT_FIRST : a + FPT_ONE;
    @(posedge CLK);
    kick <= 1'b1;
    repeat (2) @(posedge CLK);
    kick <= 1'b0;
    @(posedge CLK);
    @(negedge CLK);
    chk({7'h0, VALID}, 8'h01);
    chk({3'h0, ADDR}, {3'h0, e});
    chk(DATA, tbl(e));
  endtask
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  initial begin
    #40000;
    miscompares++;
    close_out();
  end
  initial begin
    SRST <= 1'b1;
    req <= 1'b0;
    req_addr <= 5'h00;
    step <= 1'b0;
    kick <= 1'b0;
    repeat (16) @(posedge CLK);
    SRST <= 1'b0;
    @(negedge CLK);
    chk({3'h0, ADDR, VALID}, 8'h18);
    chk({6'h0, QS, QO}, 8'h03);
    for (int a = 0; a < 32; a++) rd(a[4:0]);
    for (int i = 0; i < 40; i++) begin
      rs = xs(rs);
      rd(rs[4:0]);
    end
    refuse(5'h1F);
    refuse(5'h0C);
    rd(5'h1D);
    walk(24);
    close_out();
  end
endmodule
